// ---- hdl/refresh_pkg.sv ----
// Purpose: Shared constants and types for the dot matrix refresh controller
// Assumes: 50 MHz core clock, one clock domain
// Notes:   Column bytes carry row 7 in bit 6 down to row 1 in bit 0
package refresh_pkg;
    localparam int unsigned CLK_HZ          = 50000000;
    localparam int unsigned REFRESH_HZ      = 500;
    localparam int unsigned REFRESH_CYCLES  = CLK_HZ / REFRESH_HZ;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned FIFO_DEPTH      = 8;
    localparam int unsigned COL_W           = 5;
    localparam int unsigned ROW_BITS        = 7;
    localparam int unsigned TOP_ROW_BIT     = 6;
    localparam int unsigned HALF_SHIFT      = 4;
    localparam logic [COL_W-1:0] COL_OFF    = 5'h00;
    localparam logic [2:0] BITS_LAST        = 3'h6;

    typedef enum logic [1:0] {
        SHIFT_IDLE  = 2'b00,
        SHIFT_LOW   = 2'b01,
        SHIFT_HIGH  = 2'b10
    } shift_state_type;
endpackage

// ---- hdl/stream_if.sv ----
// Purpose: Valid/ready byte stream between controller parts
// Assumes: One clock domain
// Notes:   Transfer on valid and ready both high at a clock edge
`timescale 1ns/100ps
interface stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// ---- hdl/byte_fifo.sv ----
// Purpose: Small FIFO holding column bytes ahead of the serialiser
// Assumes: Depth is a power of two
// Notes:   Read data comes out of a register
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Fill and drain sides
    stream_if.sink    fill,
    stream_if.source  drain
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
    logic             take;
    logic             push;

    assign full        = (wr_ptr[AW] != rd_ptr[AW]) &&
                         (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty       = (wr_ptr == rd_ptr);
    assign fill.ready  = !full;
    assign push        = fill.valid && !full;
    assign take        = !empty && (!out_valid || drain.ready);
    assign drain.valid = out_valid;
    assign drain.data  = out_data;

    // Write side
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr[AW-1:0]] <= fill.data[WIDTH-1:0];
        end
    end

    // Registered read stage
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr    <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (take) begin
            rd_ptr    <= rd_ptr + 1'b1;
            out_valid <= 1'b1;
            out_data  <= store[rd_ptr[AW-1:0]];
        end else if (drain.ready) begin
            out_valid <= 1'b0;
        end
    end
endmodule

// ---- hdl/dot_matrix_refresh_controller.sv ----
// Purpose: Refresh controller between a processor bus and 5x7 LED displays
// Assumes: Processor write strobes are synchronous to core_clk
// Notes:   Display clock idles high; data loads on its falling edge
`timescale 1ns/100ps
// Contract
// - Interrupt request raised at 500 Hz
// - Data byte captured then shifted out serially
// - Exactly seven shift clocks per byte
// - Column write loads latch driving column switches
// - Bit 6 row seven down to bit 0 row one
// - One bit lights the dot
// - Serial data stable before falling clock edge
// - Column current off while data shifts
module dot_matrix_refresh_controller
    import refresh_pkg::*;
#(
    parameter int unsigned REFRESH_COUNT = REFRESH_CYCLES
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    // Processor side
    input  wire logic [refresh_pkg::DATA_W-1:0] bus_data,
    input  wire logic                    data_write,
    input  wire logic                    column_write,
    output logic                         data_ready,
    output logic                         refresh_irq,
    // Display side
    output logic                         display_data,
    output logic                         display_clock,
    output logic                         blanking_input,
    output logic [refresh_pkg::COL_W-1:0] column_drive
);
    import refresh_pkg::*;

    // Byte timing, in core cycles after the write edge:
    //   +1 byte reaches the FIFO output register
    //   +2 serialiser loads it; columns and blanking go off
    //   +7 first falling display clock, then one every eight cycles
    //   about +58 serialiser idle again; columns return a cycle later
    // Data only moves at the load or as the display clock rises, so it is settled
    // across every falling edge the display samples on.

    stream_if to_fifo ();
    stream_if from_fifo ();

    shift_state_type state;
    shift_state_type next_state;
    logic [31:0]        rate_count;
    logic               rate_tick;
    logic [DATA_W-1:0]  shift_reg;
    logic [2:0]         bit_count;
    logic [2:0]         half_count;
    logic [COL_W-1:0]   column_latch;
    logic               shifting;
    logic               fifo_ready;

    assign to_fifo.valid   = data_write;
    assign to_fifo.data    = bus_data;
    assign from_fifo.ready = (state == SHIFT_IDLE);
    assign shifting        = (state != SHIFT_IDLE) || from_fifo.valid;
    assign rate_tick       = (rate_count == REFRESH_COUNT - 1);
    assign fifo_ready      = to_fifo.ready;

    // True on the last core cycle of a display clock half period
    function automatic logic half_end(input logic [2:0] count);
        half_end = (count == 3'(HALF_SHIFT - 1));
    endfunction

    // True while the seventh bit of a byte is being clocked
    function automatic logic byte_end(input logic [2:0] count);
        byte_end = (count == BITS_LAST);
    endfunction

    byte_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) data_fifo (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .fill     (to_fifo),
        .drain    (from_fifo)
    );

    // Free running divider for the refresh rate
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_count <= '0;
        end else if (rate_tick) begin
            rate_count <= '0;
        end else begin
            rate_count <= rate_count + 1'b1;
        end
    end

    // Interrupt request; a new tick wins over the clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            refresh_irq <= 1'b0;
        end else if (rate_tick) begin
            refresh_irq <= 1'b1;
        end else if (column_write) begin
            refresh_irq <= 1'b0;
        end
    end

    // Back pressure flag for the processor
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_ready <= 1'b0;
        end else begin
            data_ready <= fifo_ready;
        end
    end

    // Next serialiser state; high half first, then low half
    always_comb begin
        next_state = state;
        case (state)
            SHIFT_IDLE: begin
                if (from_fifo.valid) begin
                    next_state = SHIFT_HIGH;
                end
            end
            SHIFT_HIGH: begin
                // Data already stable while clock is high
                if (half_end(half_count)) begin
                    next_state = SHIFT_LOW;
                end
            end
            SHIFT_LOW: begin
                if (half_end(half_count)) begin
                    if (byte_end(bit_count)) begin
                        next_state = SHIFT_IDLE;
                    end else begin
                        next_state = SHIFT_HIGH;
                    end
                end
            end
            default: begin
                next_state = SHIFT_IDLE;
            end
        endcase
    end

    // Serialiser state, one display clock per eight core cycles
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SHIFT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Parallel load, then shift towards bit 6
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= '0;
        end else if (state == SHIFT_IDLE && from_fifo.valid) begin
            shift_reg <= from_fifo.data;
        end else if (state == SHIFT_LOW && half_end(half_count)) begin
            // Move only after the falling edge has taken the bit
            shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
        end
    end

    // Bit counter limiting each byte to seven clocks
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_count <= '0;
        end else if (state == SHIFT_IDLE) begin
            bit_count <= '0;
        end else if (state == SHIFT_LOW && half_end(half_count)
                     && !byte_end(bit_count)) begin
            bit_count <= bit_count + 1'b1;
        end
    end

    // Half period counter, four core cycles per display clock level
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            half_count <= '0;
        end else if (state == SHIFT_IDLE || half_end(half_count)) begin
            half_count <= '0;
        end else begin
            half_count <= half_count + 1'b1;
        end
    end

    // Serial data pin; bit 6 (row seven) goes out first
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            display_data <= 1'b0;
        end else begin
            // Passed through uninverted, so a one lights its dot
            display_data <= shift_reg[TOP_ROW_BIT];
        end
    end

    // Display clock pin, low only through the low half period
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            display_clock <= 1'b1;
        end else begin
            display_clock <= (state != SHIFT_LOW);
        end
    end

    // Column latch loaded by the processor
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            column_latch <= COL_OFF;
        end else if (column_write) begin
            column_latch <= bus_data[COL_W-1:0];
        end
    end

    // Column drivers switched off while the string shifts
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            column_drive <= COL_OFF;
        end else begin
            column_drive <= shifting ? COL_OFF : column_latch;
        end
    end

    // Blanking held low as well, so no current spikes reach the rows
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blanking_input <= 1'b0;
        end else begin
            blanking_input <= !shifting;
        end
    end
endmodule

// ---- verif/refresh_assertions.sv ----
// Purpose: Port checks for the refresh controller
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to the design from the testbench top
`timescale 1ns/100ps
module refresh_assertions
    import refresh_pkg::*;
#(
    parameter int unsigned PERIOD = REFRESH_CYCLES
) (
    // Clock and reset
    input wire logic                      core_clk,
    input wire logic                      reset_n,
    // Processor side
    input wire logic [DATA_W-1:0]         bus_data,
    input wire logic                      data_write,
    input wire logic                      column_write,
    input wire logic                      data_ready,
    input wire logic                      refresh_irq,
    // Display side
    input wire logic                      display_data,
    input wire logic                      display_clock,
    input wire logic                      blanking_input,
    input wire logic [refresh_pkg::COL_W-1:0] column_drive
);
    logic [COL_W-1:0] col_in;
    // Column field of the bus, for delayed comparison
    assign col_in = bus_data[COL_W-1:0];
    logic [31:0] slot_count;
    logic        slot_tick;
    // Refresh slot timer at the fixed rate, restarted by reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_count <= '0;
        end else if (slot_tick) begin
            slot_count <= '0;
        end else begin
            slot_count <= slot_count + 1'b1;
        end
    end
    assign slot_tick = (slot_count == PERIOD - 1);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // One low phase of four cycles, then high again
    sequence low_pulse;
        !display_clock[*4] ##1 display_clock;
    endsequence
    // Column word written while the string stays idle
    sequence idle_col_write;
        column_write ##1 blanking_input[*3];
    endsequence
    chk_irq_clear: assert property (
        column_write && !slot_tick |=> !refresh_irq)
        else $error("irq not cleared");
    chk_irq_raise: assert property (
        slot_tick |=> refresh_irq) else $error("irq missed its slot");
    chk_irq_quiet: assert property (
        !slot_tick && !refresh_irq |=> !refresh_irq)
        else $error("irq raised between slots");
    chk_irq_hold: assert property (
        refresh_irq && !column_write |=> refresh_irq)
        else $error("irq dropped by itself");
    chk_blank_shift: assert property (
        !display_clock |-> !blanking_input && column_drive == COL_OFF)
        else $error("column current on while shifting");
    chk_data_stable: assert property (
        $fell(display_clock) |-> $stable(display_data))
        else $error("data moved at falling clock");
    chk_clk_pulse: assert property (
        $fell(display_clock) |-> low_pulse) else $error("bad clock pulse");
    chk_col_latch: assert property (
        idle_col_write |-> column_drive == $past(col_in, 3))
        else $error("column latch not shown");
    chk_start_shift: assert property (
        data_write && data_ready |-> ##[1:12] !blanking_input)
        else $error("byte not shifted");
    chk_idle_clock: assert property (
        blanking_input |-> display_clock) else $error("clock low at idle");
endmodule

// ---- verif/cpu_model.sv ----
// Purpose: Processor model writing column bytes and column words
// Assumes: Strobes change just after a rising edge
// Notes:   Bus shows the inverse of the last value when released
`timescale 1ns/100ps
module cpu_model
    import refresh_pkg::*;
(
    // Clock
    input  wire logic              core_clk,
    // Bus strobes toward the controller
    output logic [DATA_W-1:0]      bus_data,
    output logic                   data_write,
    output logic                   column_write
);
    logic [DATA_W-1:0] font [640];
    // Five groups of 128, row 7 in bit 6, one lights a dot
    initial begin
        bus_data = 8'h00;
        data_write = 1'b0;
        column_write = 1'b0;
        for (int i = 0; i < 640; i++) begin
            font[i] = 8'((i * 8'h25) & 8'h7F);
        end
    end
    // One strobe of one cycle with its value
    task automatic strobe(input logic [7:0] v, input bit col);
        @(posedge core_clk);
        #1;
        bus_data = v;
        data_write = !col;
        column_write = col;
        @(posedge core_clk);
        #1;
        data_write = 1'b0;
        column_write = 1'b0;
        bus_data = ~v;
    endtask
    // Refresh slot: one character column, then its select word
    task automatic serve(input int c, input int ch);
        strobe(font[c * 128 + ch], 1'b0);
        strobe(8'(1 << c), 1'b1);
    endtask
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the refresh controller
// Assumes: Shortened refresh count of 200 cycles
// Notes:   Falling display clock edges are captured as they come
`timescale 1ns/100ps
module tb_top;
    import refresh_pkg::*;
    localparam int unsigned REF = 200;
    localparam int unsigned CLK_NS = 20;
    logic core_clk, reset_n, data_ready, refresh_irq, data_write;
    logic column_write, display_data, display_clock, blanking_input;
    logic [DATA_W-1:0] bus_data;
    logic [COL_W-1:0]  column_drive;
    logic [6:0]        got;
    int errors, checks, falls, acc;
    time t0;
    dot_matrix_refresh_controller #(.REFRESH_COUNT(REF)) DUT (.core_clk,
        .reset_n, .bus_data, .data_write, .column_write, .data_ready,
        .refresh_irq, .display_data, .display_clock, .blanking_input,
        .column_drive);
    cpu_model cpu (.core_clk, .bus_data, .data_write, .column_write);
    initial begin
        core_clk = 1'b0;
        forever #(CLK_NS / 2) core_clk = ~core_clk;
    end
    // Serial capture at each falling display clock
    always @(negedge display_clock) begin
        got = {got[5:0], display_data};
        falls++;
    end
    task automatic compare(input logic [7:0] a, b, input string what);
        checks++;
        if (a !== b) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic wait_idle();
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 900 && blanking_input !== 1'b1; i++)
            @(posedge core_clk);
        #1;
    endtask
    task automatic t_serial();
        falls = 0;
        cpu.strobe(8'hB2, 1'b0);
        wait_idle();
        compare(8'(falls), 8'd7, "pulse count");
        compare(got, 7'h32, "serial bits");
        $display("serial test done");
    endtask
    task automatic t_column();
        cpu.strobe(8'h15, 1'b1);
        cpu.strobe(8'h7F, 1'b0);
        for (int i = 0; i < 20 && display_clock !== 1'b0; i++)
            @(posedge core_clk);
        #1;
        compare(column_drive, 5'h00, "column off in shift");
        compare(blanking_input, 1'b0, "blanking in shift");
        wait_idle();
        @(posedge core_clk);
        #1;
        compare(column_drive, 5'h15, "column latch");
        $display("column test done");
    endtask
    task automatic t_irq();
        for (int i = 0; i < 2 * REF && refresh_irq !== 1'b1; i++)
            @(posedge core_clk);
        t0 = $time;
        cpu.serve(2, 65);
        compare(refresh_irq, 1'b0, "irq cleared");
        for (int i = 0; i < 2 * REF && refresh_irq !== 1'b1; i++)
            @(posedge core_clk);
        compare(8'(($time - t0) / CLK_NS), 8'(REF), "irq period");
        cpu.serve(0, 0);
        $display("irq test done");
    endtask
    task automatic t_fifo();
        wait_idle();
        falls = 0;
        acc = 0;
        // Twelve back to back bytes overrun the buffer
        for (int i = 0; i < 12; i++) begin
            cpu.strobe(8'(i + 8'h41), 1'b0);
            // Ready just after the write edge tells whether it was taken
            acc += (data_ready === 1'b1);
        end
        compare(8'(acc < 12), 8'd1, "full fifo refuses");
        wait_idle();
        compare(8'(falls), 8'(7 * acc), "drained bytes");
        compare(data_ready, 1'b1, "ready after drain");
        $display("fifo test done");
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        t_serial();
        t_column();
        t_irq();
        t_fifo();
        test_done();
    end
    initial begin
        #(20 * 20000);
        errors++;
        test_done();
    end
endmodule
bind dot_matrix_refresh_controller refresh_assertions #(
    .PERIOD (REFRESH_COUNT)
) chk (.core_clk,
    .reset_n, .bus_data, .data_write, .column_write, .data_ready,
    .refresh_irq, .display_data, .display_clock, .blanking_input,
    .column_drive);
